/* File: pmc_pkg.sv */
// pmc_pkg: shared constants and carriers for the performance monitor counters.
// assumes a single processor clock domain; event strobes are synchronous to it.
package pmc_pkg;

    // coprocessor access decode
    localparam logic [3:0] PMC_CRM_PERF = 4'hc;
    localparam logic [2:0] PMC_OP2_CTRL = 3'h0;
    localparam logic [2:0] PMC_OP2_CYC = 3'h1;
    localparam logic [2:0] PMC_OP2_EVA = 3'h2;
    localparam logic [2:0] PMC_OP2_EVB = 3'h3;

    // control register field positions
    localparam int PMC_SEL_A_HI = 27;
    localparam int PMC_SEL_A_LO = 20;
    localparam int PMC_SEL_B_HI = 19;
    localparam int PMC_SEL_B_LO = 12;
    localparam int PMC_FLAG_HI = 10;
    localparam int PMC_FLAG_LO = 8;
    localparam int PMC_IEN_HI = 6;
    localparam int PMC_IEN_LO = 4;
    localparam int PMC_DIV_BIT = 3;
    localparam int PMC_RST_CYC_BIT = 2;
    localparam int PMC_RST_EV_BIT = 1;
    localparam int PMC_EN_BIT = 0;

    // index into flag and enable triplets
    localparam int PMC_IDX_CYC = 2;
    localparam int PMC_IDX_B = 1;
    localparam int PMC_IDX_A = 0;

    // reset values
    localparam logic [7:0] PMC_SEL_RST = 8'h00;
    localparam logic [2:0] PMC_TRIO_RST = 3'h0;
    localparam logic [31:0] PMC_WORD_ZERO = 32'h0000_0000;

    // event codes
    localparam logic [7:0] PMC_EV_ICACHE_MISS = 8'h00;
    localparam logic [7:0] PMC_EV_IBUF_STALL = 8'h01;
    localparam logic [7:0] PMC_EV_DEP_STALL = 8'h02;
    localparam logic [7:0] PMC_EV_LAST = 8'h14;
    localparam logic [7:0] PMC_EV_EVERY = 8'hff;

    // field order puts event code n at bit n of the packed value
    typedef struct packed {
        logic wr_merge;        // 0x14
        logic sbuf_drain;      // 0x13
        logic lsq_full_stall;  // 0x12
        logic ext_mem_req;     // 0x11
        logic main_tlb_miss;   // 0x10
        logic pc_changed;      // 0x0f
        logic dc_evict;        // 0x0e
        logic dc_wr_miss;      // 0x0d
        logic dc_wr;           // 0x0c
        logic dc_rd_miss;      // 0x0b
        logic dc_rd;           // 0x0a
        logic folded_exec;     // 0x09
        logic instr_exec;      // 0x08
        logic br_mispredict;   // 0x07
        logic br_not_pred;     // 0x06
        logic br_exec;         // 0x05
        logic d_utlb_miss;     // 0x04
        logic i_utlb_miss;     // 0x03
        logic dep_stall;       // 0x02
        logic ibuf_stall;      // 0x01
        logic icache_miss;     // 0x00
    } pmc_events_s;

    typedef struct packed {
        logic valid;
        logic write;
        logic [2:0] opc2;
        logic [3:0] crm;
        logic [31:0] wdata;
    } pmc_cp_req_s;

endpackage

/* File: pmc_event_counter.sv */
// pmc_event_counter: one counter with its own event selector.
// assumes events are single-cycle-per-occurrence strobes on clk.
`timescale 1ns/10ps
module pmc_event_counter
    import pmc_pkg::*;
#(
    parameter int CNT_W = 32
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // counting
    input wire logic count_on,
    input wire logic [7:0] sel,
    input wire pmc_events_s events,
    // software access
    input wire logic clear,
    input wire logic wr_en,
    input wire logic [CNT_W-1:0] wr_data,
    // state
    output logic [CNT_W-1:0] count_ff,
    output logic ovf
);
    logic [$bits(pmc_events_s)-1:0] ev_vec;
    logic hit;
    logic inc;

    generate
        if (CNT_W < 2) begin : g_bad_width
            $error("pmc_event_counter: CNT_W too small");
        end
    endgenerate

    assign ev_vec = events;

    // undefined codes never count
    always_comb begin
        hit = 1'b0;
        if (sel == PMC_EV_EVERY) begin
            hit = 1'b1;
        end else if (sel <= PMC_EV_LAST) begin
            hit = ev_vec[sel[4:0]];
        end
    end

    assign inc = count_on & hit & ~clear & ~wr_en;
    assign ovf = inc & (&count_ff);

    // software clear and load win over an increment in the same cycle
    always_ff @(posedge clk) begin
        if (!rstn) begin
            count_ff <= '0;
        end else if (clear) begin
            count_ff <= '0;
        end else if (wr_en) begin
            count_ff <= wr_data;
        end else if (inc) begin
            count_ff <= count_ff + 1'b1;
        end
    end
endmodule

/* File: pmc_top.sv */
// pmc_top: performance monitor control register, two event counters and a cycle counter.
// assumes coprocessor transfers and event strobes arrive synchronous to clk.
//
// Operation
// - control register reached with secondary opcode 0, CRm c12, full word.
// - bits 27:20 select the event for counter a.
// - bits 19:12 select the event for counter b.
// - overflow sets flag bit 10 cycle, 9 counter b, 8 counter a.
// - writing 1 clears a flag; writing 0 leaves it.
// - bits 6:4 are per-counter interrupt enables, cycle, b, a.
// - bit 3 clear counts every clock; set counts every 64th clock.
// - writing 1 to bit 2 zeroes the cycle counter.
// - writing 1 to bit 1 zeroes both event counters.
// - bit 0 enables or stops all three counters together.
// - interrupts leave on the perf interrupt output bus only.
// - counting starts three cycles after enabling.
// - codes 00, 03, 04, 10 are cache and translation misses.
// - codes 01 and 02 count every stalled cycle.
// - codes 05 to 09 are branch and instruction events.
// - codes 0a to 0e are data cache events.
// - codes 0f, 11 to 14 are further pipeline events.
// - code ff counts every cycle; undefined codes must not be used.
// - cycle counter is 32 bits and flags overflow.
// - divide option extends rollover to 2^38 cycles.
// - event counters reset to zero; cycle counter unpredictable, though this design resets it to zero as well.
// - counters accessed with opcodes 1, 2, 3 at CRm c12.
// - each event counter is 32 bits and flags overflow.
`timescale 1ns/10ps
module pmc_top
    import pmc_pkg::*;
#(
    parameter int CNT_W = 32,
    parameter int DIV_RATIO = 64,
    parameter int EN_DELAY = 3
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // coprocessor transfer
    input wire pmc_cp_req_s cp_req,
    output logic [31:0] cp_rdata_ff,
    output logic cp_rvalid_ff,
    // pipeline events
    input wire pmc_events_s events,
    // interrupt lines, index 2 cycle, 1 counter b, 0 counter a
    output logic [2:0] perf_irq_out
);
    localparam int DIV_W = $clog2(DIV_RATIO);
    localparam logic [DIV_W-1:0] DIV_MAX = DIV_W'(DIV_RATIO - 1);

    generate
        if (CNT_W != 32 || DIV_RATIO < 2 || (DIV_RATIO & (DIV_RATIO - 1)) != 0
            || EN_DELAY != 3) begin : g_bad_params
            $error("pmc_top: unsupported parameter values");
        end
    endgenerate

    logic [7:0] event_select_a_ff;
    logic [7:0] event_select_b_ff;
    logic [2:0] overflow_irq_enables_ff;
    logic [2:0] flag_ff;
    logic div_ff;
    logic en_ff;
    logic [EN_DELAY-2:0] en_pipe_ff;
    logic [DIV_W-1:0] prescale_ff;
    logic [2:0] irq_ff;
    logic count_on;
    logic cyc_tick;
    logic cp_hit;
    logic ctl_wr;
    logic cyc_wr;
    logic eva_wr;
    logic evb_wr;
    logic rst_cyc;
    logic rst_ev;
    logic [2:0] ovf;
    logic [CNT_W-1:0] event_counter_a;
    logic [CNT_W-1:0] event_counter_b;
    logic [CNT_W-1:0] cycle_counter;
    logic [31:0] perf_monitor_control;
    logic [31:0] nxt_rdata;

    // decode
    assign cp_hit = cp_req.valid & (cp_req.crm == PMC_CRM_PERF);
    assign ctl_wr = cp_hit & cp_req.write & (cp_req.opc2 == PMC_OP2_CTRL);
    assign cyc_wr = cp_hit & cp_req.write & (cp_req.opc2 == PMC_OP2_CYC);
    assign eva_wr = cp_hit & cp_req.write & (cp_req.opc2 == PMC_OP2_EVA);
    assign evb_wr = cp_hit & cp_req.write & (cp_req.opc2 == PMC_OP2_EVB);
    assign rst_cyc = ctl_wr & cp_req.wdata[PMC_RST_CYC_BIT];
    assign rst_ev = ctl_wr & cp_req.wdata[PMC_RST_EV_BIT];

    // control fields; reserved bits are never stored
    always_ff @(posedge clk) begin
        if (!rstn) begin
            event_select_a_ff <= PMC_SEL_RST;
            event_select_b_ff <= PMC_SEL_RST;
            overflow_irq_enables_ff <= PMC_TRIO_RST;
            div_ff <= 1'b0;
            en_ff <= 1'b0;
        end else if (ctl_wr) begin
            event_select_a_ff <= cp_req.wdata[PMC_SEL_A_HI:PMC_SEL_A_LO];
            event_select_b_ff <= cp_req.wdata[PMC_SEL_B_HI:PMC_SEL_B_LO];
            overflow_irq_enables_ff <= cp_req.wdata[PMC_IEN_HI:PMC_IEN_LO];
            div_ff <= cp_req.wdata[PMC_DIV_BIT];
            en_ff <= cp_req.wdata[PMC_EN_BIT];
        end
    end

    // overflow flags: a new overflow wins over a clearing write
    always_ff @(posedge clk) begin
        if (!rstn) begin
            flag_ff <= PMC_TRIO_RST;
        end else begin
            flag_ff <= (flag_ff & ~({3{ctl_wr}} & cp_req.wdata[PMC_FLAG_HI:PMC_FLAG_LO]))
                       | ovf;
        end
    end

    // enable pipeline mirrors the pipeline's start-up latency
    always_ff @(posedge clk) begin
        if (!rstn) begin
            en_pipe_ff <= '0;
        end else begin
            en_pipe_ff <= {en_pipe_ff[EN_DELAY-3:0], en_ff};
        end
    end
    assign count_on = en_ff & en_pipe_ff[EN_DELAY-2];

    // prescaler; cleared with the cycle counter so a reset restarts a full period
    always_ff @(posedge clk) begin
        if (!rstn) begin
            prescale_ff <= '0;
        end else if (rst_cyc || cyc_wr) begin
            prescale_ff <= '0;
        end else if (count_on && div_ff) begin
            prescale_ff <= prescale_ff + 1'b1;
        end
    end
    assign cyc_tick = count_on & (~div_ff | (prescale_ff == DIV_MAX));

    // counters; cycle counter reuses the selector fed with the every-cycle code
    pmc_event_counter #(.CNT_W(CNT_W)) u_cnt_a (
        .clk(clk),
        .rstn(rstn),
        .count_on(count_on),
        .sel(event_select_a_ff),
        .events(events),
        .clear(rst_ev),
        .wr_en(eva_wr),
        .wr_data(cp_req.wdata),
        .count_ff(event_counter_a),
        .ovf(ovf[PMC_IDX_A])
    );

    pmc_event_counter #(.CNT_W(CNT_W)) u_cnt_b (
        .clk(clk),
        .rstn(rstn),
        .count_on(count_on),
        .sel(event_select_b_ff),
        .events(events),
        .clear(rst_ev),
        .wr_en(evb_wr),
        .wr_data(cp_req.wdata),
        .count_ff(event_counter_b),
        .ovf(ovf[PMC_IDX_B])
    );

    pmc_event_counter #(.CNT_W(CNT_W)) u_cnt_cyc (
        .clk(clk),
        .rstn(rstn),
        .count_on(cyc_tick),
        .sel(PMC_EV_EVERY),
        .events(events),
        .clear(rst_cyc),
        .wr_en(cyc_wr),
        .wr_data(cp_req.wdata),
        .count_ff(cycle_counter),
        .ovf(ovf[PMC_IDX_CYC])
    );

    // reset bits read back as zero, a safe pick for an unpredictable read
    always_comb begin
        perf_monitor_control = PMC_WORD_ZERO;
        perf_monitor_control[PMC_SEL_A_HI:PMC_SEL_A_LO] = event_select_a_ff;
        perf_monitor_control[PMC_SEL_B_HI:PMC_SEL_B_LO] = event_select_b_ff;
        perf_monitor_control[PMC_FLAG_HI:PMC_FLAG_LO] = flag_ff;
        perf_monitor_control[PMC_IEN_HI:PMC_IEN_LO] = overflow_irq_enables_ff;
        perf_monitor_control[PMC_DIV_BIT] = div_ff;
        perf_monitor_control[PMC_EN_BIT] = en_ff;
    end

    always_comb begin
        case (cp_req.opc2)
            PMC_OP2_CTRL: nxt_rdata = perf_monitor_control;
            PMC_OP2_CYC: nxt_rdata = cycle_counter;
            PMC_OP2_EVA: nxt_rdata = event_counter_a;
            PMC_OP2_EVB: nxt_rdata = event_counter_b;
            default: nxt_rdata = PMC_WORD_ZERO;
        endcase
    end

    // read answer one cycle after the request
    always_ff @(posedge clk) begin
        if (!rstn) begin
            cp_rdata_ff <= PMC_WORD_ZERO;
            cp_rvalid_ff <= 1'b0;
        end else begin
            cp_rvalid_ff <= cp_hit & ~cp_req.write;
            if (cp_hit && !cp_req.write) begin
                cp_rdata_ff <= nxt_rdata;
            end
        end
    end

    // level interrupt per counter; masking beyond this is the controller's job
    always_ff @(posedge clk) begin
        if (!rstn) begin
            irq_ff <= PMC_TRIO_RST;
        end else begin
            irq_ff <= flag_ff & overflow_irq_enables_ff;
        end
    end
    assign perf_irq_out = irq_ff;

    // checks
    property p_sel_a;
        @(posedge clk) disable iff (!rstn)
        ctl_wr |=> event_select_a_ff == $past(cp_req.wdata[PMC_SEL_A_HI:PMC_SEL_A_LO]);
    endproperty
    a_sel_a: assert property (p_sel_a) else $error("select a not loaded");

    property p_sel_b;
        @(posedge clk) disable iff (!rstn)
        ctl_wr |=> event_select_b_ff == $past(cp_req.wdata[PMC_SEL_B_HI:PMC_SEL_B_LO]);
    endproperty
    a_sel_b: assert property (p_sel_b) else $error("select b not loaded");

    property p_ovf_flag;
        @(posedge clk) disable iff (!rstn)
        ovf[PMC_IDX_CYC] |=> flag_ff[PMC_IDX_CYC] && cycle_counter == '0;
    endproperty
    a_ovf_flag: assert property (p_ovf_flag) else $error("cycle overflow not flagged");

    property p_flag_clear;
        @(posedge clk) disable iff (!rstn)
        ctl_wr && cp_req.wdata[PMC_FLAG_LO] && !ovf[PMC_IDX_A] |=> !flag_ff[PMC_IDX_A];
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag a not cleared");

    property p_irq;
        @(posedge clk) disable iff (!rstn)
        ##1 perf_irq_out == $past(flag_ff & overflow_irq_enables_ff);
    endproperty
    a_irq: assert property (p_irq) else $error("irq line mismatch");

    property p_start_delay;
        @(posedge clk) disable iff (!rstn)
        $rose(en_ff) |-> !count_on ##1 !count_on ##1 (count_on || !en_ff);
    endproperty
    a_start_delay: assert property (p_start_delay) else $error("start delay wrong");

    property p_div;
        @(posedge clk) disable iff (!rstn)
        count_on && div_ff && !cp_hit && prescale_ff != DIV_MAX |=> $stable(cycle_counter);
    endproperty
    a_div: assert property (p_div) else $error("divided tick too early");

    property p_div_tick;
        @(posedge clk) disable iff (!rstn)
        count_on && div_ff && !cp_hit && prescale_ff == DIV_MAX
        |=> cycle_counter == $past(cycle_counter) + 1'b1;
    endproperty
    a_div_tick: assert property (p_div_tick) else $error("divided tick missed");

    property p_cyc_load;
        @(posedge clk) disable iff (!rstn)
        cyc_wr |=> cycle_counter == $past(cp_req.wdata);
    endproperty
    a_cyc_load: assert property (p_cyc_load) else $error("cycle counter not loaded");

    property p_rst_cyc;
        @(posedge clk) disable iff (!rstn)
        rst_cyc |=> cycle_counter == '0;
    endproperty
    a_rst_cyc: assert property (p_rst_cyc) else $error("cycle counter not reset");

    property p_rst_ev;
        @(posedge clk) disable iff (!rstn)
        rst_ev |=> event_counter_a == '0 && event_counter_b == '0;
    endproperty
    a_rst_ev: assert property (p_rst_ev) else $error("event counters not reset");

    property p_stopped;
        @(posedge clk) disable iff (!rstn)
        !en_ff && !cp_hit |=> $stable(cycle_counter) && $stable(event_counter_a);
    endproperty
    a_stopped: assert property (p_stopped) else $error("counted while disabled");

    property p_every;
        @(posedge clk) disable iff (!rstn)
        count_on && event_select_b_ff == PMC_EV_EVERY && !cp_hit
        |=> event_counter_b == $past(event_counter_b) + 1'b1;
    endproperty
    a_every: assert property (p_every) else $error("every-cycle code missed");

    c_ovf_a: cover property (@(posedge clk) disable iff (!rstn) ovf[PMC_IDX_A]);
    c_irq: cover property (@(posedge clk) disable iff (!rstn) |perf_irq_out);
    c_div_tick: cover property (@(posedge clk) disable iff (!rstn) cyc_tick && div_ff);
endmodule

/* File: pmc_event_model.sv */
// pmc_event_model: pipeline event sources and a latching interrupt controller.
// assumes the bench commands one event code at a time, changed at a rising edge.
`timescale 1ns/10ps
module pmc_event_model
    import pmc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // command from the bench
    input wire logic [7:0] code,
    input wire logic active,
    // pipeline side
    output pmc_events_s events,
    // interrupt controller side
    input wire logic [2:0] irq,
    input wire logic irq_ack,
    output logic [2:0] irq_seen_ff
);
    logic [31:0] one_hot;

    // codes above 0x14 fall off the top, so no strobe at all
    assign one_hot = 32'h0000_0001 << code;

    // a held level repeats every cycle, as a persisting stall does
    always_ff @(posedge clk) begin
        if (!rstn || !active) begin
            events <= 21'h0_0000;
        end else begin
            events <= one_hot[20:0];
        end
    end

    // level lines latched until the handler acknowledges
    always_ff @(posedge clk) begin
        if (!rstn || irq_ack) begin
            irq_seen_ff <= 3'h0;
        end else begin
            irq_seen_ff <= irq_seen_ff | irq;
        end
    end
endmodule

/* File: pmc_top_tb_top.sv */
// pmc_top_tb_top: self-checking bench for the performance monitor counters.
// assumes the event model and the pmc_top design are compiled alongside.
`timescale 1ns/10ps
module pmc_top_tb_top
    import pmc_pkg::*;
;
    logic clk;
    logic rstn;
    pmc_cp_req_s cp_req;
    logic [31:0] cp_rdata_ff;
    logic cp_rvalid_ff;
    pmc_events_s events;
    logic [2:0] perf_irq_out;
    logic [7:0] ev_code;
    logic ev_on;
    logic irq_ack;
    logic [2:0] irq_seen;
    int num_errors;
    int n_compared;
    int cyc_cnt = 0;

    pmc_top pmc_top_i (
        .clk(clk),
        .rstn(rstn),
        .cp_req(cp_req),
        .cp_rdata_ff(cp_rdata_ff),
        .cp_rvalid_ff(cp_rvalid_ff),
        .events(events),
        .perf_irq_out(perf_irq_out)
    );

    pmc_event_model pmc_event_model_i (
        .clk(clk),
        .rstn(rstn),
        .code(ev_code),
        .active(ev_on),
        .events(events),
        .irq(perf_irq_out),
        .irq_ack(irq_ack),
        .irq_seen_ff(irq_seen)
    );

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ceiling well above the roughly 650 cycles the tests need
    always @(posedge clk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 5000) begin
            num_errors++;
            complete_run();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // request held for one edge; read answer sampled after the next
    task automatic cp_op(input logic wr, input logic [2:0] op, input logic [3:0] crm,
                         input logic [31:0] wd, output logic [31:0] rd, output logic rv);
        @(posedge clk);
        cp_req <= '{1'b1, wr, op, crm, wd};
        @(posedge clk);
        cp_req.valid <= 1'b0;
        #1;
        rv = cp_rvalid_ff;
        rd = cp_rdata_ff;
    endtask

    task automatic wr_reg(input logic [2:0] op, input logic [31:0] wd);
        logic [31:0] d;
        logic v;
        cp_op(1'b1, op, PMC_CRM_PERF, wd, d, v);
    endtask

    task automatic rd_chk(input logic [2:0] op, input logic [31:0] exp);
        logic [31:0] d;
        logic v;
        cp_op(1'b0, op, PMC_CRM_PERF, 32'h0000_0000, d, v);
        chk({31'h0, v}, 32'h0000_0001);
        chk(d, exp);
    endtask

    task automatic t_reset();
        rd_chk(PMC_OP2_CTRL, 32'h0000_0000);
        rd_chk(PMC_OP2_EVA, 32'h0000_0000);
        rd_chk(PMC_OP2_EVB, 32'h0000_0000);
        chk({29'h0, perf_irq_out}, 32'h0000_0000);
        $display("test reset done");
    endtask

    task automatic t_fields();
        wr_reg(PMC_OP2_CTRL, 32'hFFFF_FFFF);
        rd_chk(PMC_OP2_CTRL, 32'h0FFF_F079);
        wr_reg(PMC_OP2_CTRL, 32'h0000_0000);
        $display("test fields done");
    endtask

    // counts run from the third edge after the enabling write
    task automatic t_count();
        @(posedge clk);
        ev_code <= PMC_EV_DEP_STALL;
        ev_on <= 1'b1;
        wr_reg(PMC_OP2_CTRL, 32'h002F_F007);
        repeat (20) @(posedge clk);
        rd_chk(PMC_OP2_EVA, 32'h0000_0013);
        rd_chk(PMC_OP2_EVB, 32'h0000_0015);
        rd_chk(PMC_OP2_CYC, 32'h0000_0017);
        wr_reg(PMC_OP2_CTRL, 32'h002F_F006);
        repeat (10) @(posedge clk);
        rd_chk(PMC_OP2_EVA, 32'h0000_0000);
        rd_chk(PMC_OP2_CYC, 32'h0000_0000);
        $display("test count done");
    endtask

    // counter b watches a neighbouring code and must stay still
    task automatic t_codes();
        logic [7:0] c;
        for (int i = 0; i <= 20; i++) begin
            c = i[7:0];
            @(posedge clk);
            ev_code <= c;
            wr_reg(PMC_OP2_CTRL, {4'h0, c, c ^ 8'h01, 12'h007});
            repeat (10) @(posedge clk);
            rd_chk(PMC_OP2_EVA, 32'h0000_0009);
            rd_chk(PMC_OP2_EVB, 32'h0000_0000);
            wr_reg(PMC_OP2_CTRL, 32'h0000_0000);
        end
        $display("test codes done");
    endtask

    task automatic t_irq();
        @(posedge clk);
        ev_on <= 1'b0;
        wr_reg(PMC_OP2_EVA, 32'hFFFF_FFFE);
        wr_reg(PMC_OP2_EVB, 32'hFFFF_FFFE);
        wr_reg(PMC_OP2_CYC, 32'hFFFF_FFFE);
        wr_reg(PMC_OP2_CTRL, 32'h0FFF_F051);
        repeat (4) @(posedge clk);
        #1;
        chk({29'h0, perf_irq_out}, 32'h0000_0000);
        @(posedge clk);
        #1;
        chk({29'h0, perf_irq_out}, 32'h0000_0005);
        rd_chk(PMC_OP2_CTRL, 32'h0FFF_F751);
        wr_reg(PMC_OP2_CTRL, 32'h0FFF_F250);
        rd_chk(PMC_OP2_CTRL, 32'h0FFF_F550);
        chk({29'h0, perf_irq_out}, 32'h0000_0005);
        wr_reg(PMC_OP2_CTRL, 32'h0FFF_F550);
        rd_chk(PMC_OP2_CTRL, 32'h0FFF_F050);
        chk({29'h0, perf_irq_out}, 32'h0000_0000);
        chk({29'h0, irq_seen}, 32'h0000_0005);
        @(posedge clk);
        irq_ack <= 1'b1;
        @(posedge clk);
        irq_ack <= 1'b0;
        $display("test irq done");
    endtask

    // 128 enabled cycles gives two ticks whichever phase the divider uses
    task automatic t_div();
        wr_reg(PMC_OP2_CTRL, 32'h0000_000D);
        repeat (129) @(posedge clk);
        rd_chk(PMC_OP2_CYC, 32'h0000_0002);
        wr_reg(PMC_OP2_CTRL, 32'h0000_0000);
        $display("test div done");
    endtask

    task automatic t_refuse();
        logic [31:0] d;
        logic v;
        cp_op(1'b1, PMC_OP2_CTRL, 4'h3, 32'h0000_0071, d, v);
        cp_op(1'b0, PMC_OP2_CTRL, 4'h3, 32'h0000_0000, d, v);
        chk({31'h0, v}, 32'h0000_0000);
        cp_op(1'b0, 3'h5, PMC_CRM_PERF, 32'h0000_0000, d, v);
        chk({31'h0, v}, 32'h0000_0001);
        chk(d, 32'h0000_0000);
        rd_chk(PMC_OP2_CTRL, 32'h0000_0000);
        $display("test refuse done");
    endtask

    // reset in mid-run with counter a wrapped and its interrupt standing
    task automatic t_midrst();
        wr_reg(PMC_OP2_EVA, 32'hFFFF_FFFF);
        wr_reg(PMC_OP2_CTRL, 32'h0FF0_0011);
        repeat (6) @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rd_chk(PMC_OP2_CTRL, 32'h0000_0000);
        rd_chk(PMC_OP2_EVA, 32'h0000_0000);
        chk({29'h0, perf_irq_out}, 32'h0000_0000);
        $display("test midrst done");
    endtask

    initial begin
        rstn = 1'b0;
        cp_req = '{1'b0, 1'b0, 3'h0, 4'h0, 32'h0000_0000};
        ev_code = 8'h00;
        ev_on = 1'b0;
        irq_ack = 1'b0;
        num_errors = 0;
        n_compared = 0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        t_reset();
        t_fields();
        t_count();
        t_codes();
        t_irq();
        t_div();
        t_refuse();
        t_midrst();
        complete_run();
    end
endmodule
